/* dv/tca_host.sv */
/* host processor model: single-word register writes and reads
   assumes one caller at a time, strobes sampled on the rising edge */
`timescale 1ns/1ps
module tca_host (
    input  wire logic        clk_in,    // system clock
    output logic [9:0]       addr_out,  // register address
    output logic             wr_out,    // write strobe
    output logic             rd_out,    // read strobe
    output logic [15:0]      wdata_out, // write data
    input  wire logic [15:0] rdata_in   // read data
);
    initial begin
        {addr_out, wr_out, rd_out, wdata_out} = '0;
    end
    // callers pass zero in reserved bits and legal skip counts
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'b1;
        @(posedge clk_in);
        wr_out    <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, output logic [15:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge clk_in);
        rd_out   <= 1'b0;
        @(negedge clk_in);
        d = rdata_in;
    endtask
endmodule // tca_host

/* dv/tca_monitor.sv */
/* checker for the ambient compensation register bank, bound to tca_regs
   assumes it sees only the ports of tca_regs */
`timescale 1ns/1ps
module tca_monitor
    import tca_pkg::*;
#(
    parameter int STAGES = TCA_STAGES         // conversion steps
) (
    input wire logic              clk_in,            // clock
    input wire logic              rst_b_in,          // reset, low
    input wire logic [9:0]        reg_addr_in,       // address
    input wire logic              reg_wr_in,         // write strobe
    input wire logic              reg_rd_in,         // read strobe
    input wire logic [15:0]       reg_wdata_in,      // write data
    input wire logic [15:0]       reg_rdata_out,     // read data
    input wire logic              seq_done_in,       // sequence done
    input wire logic              full_power_in,     // full power
    input wire logic [STAGES-1:0] stage_low_in,      // low hits
    input wire logic              fifo_admit_out,    // admit
    input wire logic              power_drop_out,    // power drop
    input wire logic              force_recal_out,   // forced cal
    input wire logic              seq_restart_out,   // restart
    input wire logic [9:0]        fp_recal_time_out, // fp time
    input wire logic [5:0]        lp_recal_time_out, // lp time
    input wire logic              gpio_oe_out,       // pin enable
    input wire logic              low_irq_out        // low irq
);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    wire logic wr_a = reg_wr_in && reg_addr_in == TCA_OFS_CTRL_A;
    wire logic wr_c = reg_wr_in && reg_addr_in == TCA_OFS_CTRL_C;
    wire logic wr_e = reg_wr_in && reg_addr_in == TCA_OFS_LOWEN;
    wire logic rd_a = reg_rd_in && reg_addr_in == TCA_OFS_CTRL_A;

    property p_admit; fifo_admit_out |-> seq_done_in; endproperty
    a_admit: assert property (p_admit)
        else $error("admit without a finished sequence");
    property p_rst; wr_a && reg_wdata_in[15] |=> seq_restart_out; endproperty
    a_rst: assert property (p_rst)
        else $error("restart write gave no pulse");
    property p_rst_src;
        seq_restart_out |-> $past(wr_a && reg_wdata_in[15]);
    endproperty
    a_rst_src: assert property (p_rst_src)
        else $error("restart pulse without its write");
    property p_rd15; rd_a |=> !reg_rdata_out[15]; endproperty
    a_rd15: assert property (p_rd15)
        else $error("restart bit read back as one");
    property p_force;
        wr_a |=> force_recal_out == $past(reg_wdata_in[14]);
    endproperty
    a_force: assert property (p_force)
        else $error("forced calibration level wrong");
    property p_fp; wr_c |=> fp_recal_time_out == $past(reg_wdata_in[9:0]);
    endproperty
    a_fp: assert property (p_fp)
        else $error("full power recal time not taken");
    property p_lp;
        wr_c |=> lp_recal_time_out == $past(reg_wdata_in[15:10]);
    endproperty
    a_lp: assert property (p_lp)
        else $error("low power recal time not taken");
    property p_irq; !(|stage_low_in) |=> !low_irq_out; endproperty
    a_irq: assert property (p_irq)
        else $error("low irq with no low hit");
    property p_oe; wr_e && !reg_wdata_in[13] |=> ##1 !gpio_oe_out;
    endproperty
    a_oe: assert property (p_oe)
        else $error("pin driven in off or input role");
    property p_drop; power_drop_out |-> $past(full_power_in); endproperty
    a_drop: assert property (p_drop)
        else $error("power drop outside full power");
    c_admit: cover property (fifo_admit_out);
    c_rst: cover property (seq_restart_out);
    c_drop: cover property (power_drop_out);
endmodule // tca_monitor

bind tca_regs tca_monitor #(.STAGES(STAGES)) mon (.*);

/* dv/touch_cdc_ambient_comp_regs_bench.sv */
/* self-checking bench for tca_regs with the host model on its bus
   assumes the monitor is bound from its own file */
`timescale 1ns/1ps
module touch_cdc_ambient_comp_regs_bench
    import tca_pkg::*;
;
    logic clk_in, rst_b_in, reg_wr_in, reg_rd_in, seq_done_in;
    logic full_power_in, near_touch_in, gpio_assert_in, gpio_pin_in;
    logic gpio_pin_out, gpio_oe_out, gpio_trig_out, fifo_admit_out;
    logic cal_suspend_out, power_drop_out, force_recal_out, low_irq_out;
    logic seq_restart_out;
    logic [9:0]  reg_addr_in, fp_recal_time_out;
    logic [15:0] reg_wdata_in, reg_rdata_out, v;
    logic [11:0] stage_low_in;
    logic [7:0]  near_recal_lvl_out;
    logic [5:0]  near_rate_out, lp_recal_time_out;
    logic [1:0]  slow_update_lvl_out;
    logic        a, d;
    int          mismatches = 0, comparisons = 0, cnt;

    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    tca_host host (.clk_in(clk_in), .addr_out(reg_addr_in),
        .wr_out(reg_wr_in), .rd_out(reg_rd_in),
        .wdata_out(reg_wdata_in), .rdata_in(reg_rdata_out));
    tca_regs dut (.*);

    task automatic chk(input string nm, input logic [15:0] e, g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic seq;
        @(posedge clk_in) seq_done_in <= 1'b1;
        @(negedge clk_in) a = fifo_admit_out;
        @(posedge clk_in) seq_done_in <= 1'b0;
        @(negedge clk_in) d = power_drop_out;
        @(negedge clk_in) d = d | power_drop_out;
    endtask
    task automatic touch;
        @(posedge clk_in) near_touch_in <= 1'b1;
        @(posedge clk_in) near_touch_in <= 1'b0;
        @(negedge clk_in);
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        logic [9:0]  ad [5] = '{TCA_OFS_CTRL_A, TCA_OFS_CTRL_B,
            TCA_OFS_CTRL_C, TCA_OFS_LOWEN, 10'h006};
        logic [15:0] ex [5] = '{16'h0FF0, 16'h0140, 16'hFFFF, 16'h0, 16'h0};
        for (int i = 0; i < 5; i++) begin
            host.rd(ad[i], v);
            chk("reset value", ex[i], v);
        end
        chk("fp time", 16'h03FF, {6'h0, fp_recal_time_out});
    endtask
    task automatic t_force;
        host.wr(TCA_OFS_CTRL_A, 16'h4FF0);
        @(negedge clk_in);
        chk("force", 16'h1, {15'h0, force_recal_out});
        host.wr(TCA_OFS_CTRL_A, 16'h8FF0);
        @(negedge clk_in);
        chk("restart", 16'h1, {15'h0, seq_restart_out});
        @(negedge clk_in);
        chk("restart end", 16'h0, {15'h0, seq_restart_out});
        chk("force off", 16'h0, {15'h0, force_recal_out});
        host.rd(TCA_OFS_CTRL_A, v);
        chk("ctrl_a", 16'h0FF0, v);
    endtask
    // every field of the two plain control words, by output and read-back
    task automatic t_cfg;
        host.wr(TCA_OFS_CTRL_B, 16'hA5C3);
        host.wr(TCA_OFS_CTRL_C, 16'h5A96);
        @(negedge clk_in);
        chk("near lvl", 16'h00C3, {8'h0, near_recal_lvl_out});
        chk("near rate", 16'h0025, {10'h0, near_rate_out});
        chk("slow lvl", 16'h0002, {14'h0, slow_update_lvl_out});
        chk("fp time", 16'h0296, {6'h0, fp_recal_time_out});
        chk("lp time", 16'h0016, {10'h0, lp_recal_time_out});
        host.rd(TCA_OFS_CTRL_B, v);
        chk("ctrl_b", 16'hA5C3, v);
        host.rd(TCA_OFS_CTRL_C, v);
        chk("ctrl_c", 16'h5A96, v);
    endtask
    task automatic t_skip;
        logic [3:0] nv [3] = '{4'h0, 4'h2, TCA_SKIP_MAX};
        foreach (nv[k]) begin
            host.wr(TCA_OFS_CTRL_A, {12'h8FF, nv[k]});
            cnt = 0;
            repeat (2 * (nv[k] + 1)) begin
                seq();
                if (a === 1'b1) cnt++;
            end
            chk("admits", 16'h2, cnt[15:0]);
        end
    endtask
    task automatic t_hold;
        for (int m = 0; m < 2; m++) begin
            @(posedge clk_in) full_power_in <= m[0];
            host.wr(TCA_OFS_CTRL_A, 16'h8110);
            touch();
            chk("suspend", 16'h1, {15'h0, cal_suspend_out});
            cnt = 0;
            while (cal_suspend_out === 1'b1 && cnt < 80) begin
                seq();
                cnt++;
            end
            chk("hold len", m ? 16'h10 : 16'h4, cnt[15:0]);
        end
    endtask
    task automatic t_drop;
        for (int s = 0; s < 4; s++) begin
            host.wr(TCA_OFS_CTRL_A, {2'h2, s[1:0], 12'h110});
            touch();
            cnt = 0;
            d = 1'b0;
            while (d !== 1'b1 && cnt < 60) begin
                seq();
                cnt++;
            end
            chk("drop len", 16'(4 * (5 + s)), cnt[15:0]);
        end
    endtask
    task automatic t_irq;
        for (int i = 0; i < TCA_STAGES; i++) begin
            host.wr(TCA_OFS_LOWEN, 16'(1 << i));
            @(posedge clk_in) stage_low_in <= 12'(1 << i);
            repeat (2) @(negedge clk_in);
            chk("irq hit", 16'h1, {15'h0, low_irq_out});
            @(posedge clk_in) stage_low_in <= ~12'(1 << i);
            repeat (2) @(negedge clk_in);
            chk("irq masked", 16'h0, {15'h0, low_irq_out});
        end
    endtask
    task automatic t_gpio;
        for (int s = 0; s < 4; s++) begin
            host.wr(TCA_OFS_LOWEN, {2'h0, s[1:0], 12'h0});
            repeat (3) @(negedge clk_in);
            chk("oe", 16'(s >> 1), {15'h0, gpio_oe_out});
            if (s > 1) begin
                chk("pin", 16'(s & 1), {15'h0, gpio_pin_out});
                @(posedge clk_in) gpio_assert_in <= 1'b0;
                repeat (2) @(negedge clk_in);
                chk("pin idle", 16'(~s & 1), {15'h0, gpio_pin_out});
                @(posedge clk_in) gpio_assert_in <= 1'b1;
            end
        end
        for (int t = 0; t < 4; t++) begin
            host.wr(TCA_OFS_LOWEN, {t[1:0], 2'h1, 12'h0});
            @(posedge clk_in) gpio_pin_in <= ~t[0];
            repeat (6) @(negedge clk_in);
            chk("trig idle", 16'h0, {15'h0, gpio_trig_out});
            @(posedge clk_in) gpio_pin_in <= t[0];
            cnt = 0;
            repeat (8) begin
                @(negedge clk_in);
                if (gpio_trig_out === 1'b1) cnt++;
            end
            chk("trig seen", 16'h1, 16'(cnt != 0));
            chk("trig edge", 16'(t[0] ^ t[1]), 16'(cnt == 1));
        end
    endtask

    initial begin
        {rst_b_in, seq_done_in, full_power_in, near_touch_in} = '0;
        {gpio_assert_in, gpio_pin_in, stage_low_in} = {2'h3, 12'h0};
        repeat (20) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_reset();
        t_force();
        t_cfg();
        t_skip();
        t_hold();
        t_drop();
        t_irq();
        t_gpio();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        mismatches++;
        close_out();
    end
endmodule // touch_cdc_ambient_comp_regs_bench

/* rtl/tca_gpio_pin.sv */
/*
 * General-purpose pin unit: role selection, input synchroniser and
 * trigger detection, output drive.
 * Assumes the pin is asynchronous to clk_in; the pad resolves the wire.
 */
`timescale 1ns/1ps

module tca_gpio_pin
    import tca_pkg::*;
(
    input  wire logic       clk_in,        // system clock
    input  wire logic       rst_b_in,      // async reset, active low
    input  wire logic [1:0] setup_in,      // pin role
    input  wire logic [1:0] trig_in,       // input trigger condition
    input  wire logic       assert_in,     // output asserted request
    input  wire logic       pin_in,        // pad level
    output logic            pin_out,       // pad drive value
    output logic            pin_oe_out,    // pad drive enable
    output logic            trig_out       // input trigger seen
);

    logic       sync1_ff;
    logic       sync2_ff;
    logic       prev_ff;
    logic       pin_ff;
    logic       oe_ff;
    logic       trig_ff;
    logic       nxt_trig;
    wire        is_input = (setup_in == TCA_GPIO_IN);

    // ------------------------------------------------------------------
    // synchroniser; only sync2_ff and later stages are looked at
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // ------------------------------------------------------------------
    // trigger select
    // ------------------------------------------------------------------
    always_comb begin
        nxt_trig = 1'b0;
        if (is_input) begin
            case (trig_in)
                TCA_TRIG_NLVL:  nxt_trig = ~sync2_ff;
                TCA_TRIG_PEDGE: nxt_trig = sync2_ff & ~prev_ff;
                TCA_TRIG_NEDGE: nxt_trig = ~sync2_ff & prev_ff;
                TCA_TRIG_PLVL:  nxt_trig = sync2_ff;
                default:        nxt_trig = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_ff  <= 1'b0;
            oe_ff   <= 1'b0;
            trig_ff <= 1'b0;
        end else begin
            oe_ff   <= setup_in[1];
            pin_ff  <= (setup_in == TCA_GPIO_OUT_H) ? assert_in
                                                    : ~assert_in;
            trig_ff <= nxt_trig;
        end
    end

    assign pin_out    = pin_ff;
    assign pin_oe_out = oe_ff;
    assign trig_out   = trig_ff;

endmodule // tca_gpio_pin

/* rtl/tca_pkg.sv */
/*
 * Shared constants of the ambient compensation register bank: register
 * offsets, field positions, reset values and field codes.
 * Assumes a 10-bit register address space reached over the serial port.
 */
package tca_pkg;

    localparam int          TCA_ADDR_W = 10;
    localparam int          TCA_DATA_W = 16;
    localparam int          TCA_STAGES = 12;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [9:0]  TCA_OFS_CTRL_A = 10'h002;
    localparam logic [9:0]  TCA_OFS_CTRL_B = 10'h003;
    localparam logic [9:0]  TCA_OFS_CTRL_C = 10'h004;
    localparam logic [9:0]  TCA_OFS_LOWEN  = 10'h005;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] TCA_RST_CTRL_A = 16'h0FF0;
    localparam logic [15:0] TCA_RST_CTRL_B = 16'h0140;
    localparam logic [15:0] TCA_RST_CTRL_C = 16'hFFFF;
    localparam logic [15:0] TCA_RST_LOWEN  = 16'h0000;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int          TCA_SKIP_LSB   = 0;
    localparam int          TCA_FPHOLD_LSB = 4;
    localparam int          TCA_LPHOLD_LSB = 8;
    localparam int          TCA_TMO_LSB    = 12;
    localparam int          TCA_FORCE_BIT  = 14;
    localparam int          TCA_RESTART_BIT = 15;
    localparam int          TCA_NEAR_LVL_LSB = 0;
    localparam int          TCA_NEAR_RATE_LSB = 8;
    localparam int          TCA_SLOW_LVL_LSB = 14;
    localparam int          TCA_FPRECAL_LSB = 0;
    localparam int          TCA_LPRECAL_LSB = 10;
    localparam int          TCA_GPIO_SETUP_LSB = 12;
    localparam int          TCA_GPIO_TRIG_LSB = 14;

    // ------------------------------------------------------------------
    // field codes and multipliers
    // ------------------------------------------------------------------
    localparam logic [3:0]  TCA_SKIP_MAX   = 4'hC;
    localparam int          TCA_FP_MULT_SH = 4;   // x16 sequences
    localparam int          TCA_LP_MULT_SH = 2;   // x4 sequences
    localparam logic [3:0]  TCA_TMO_BASE   = 4'h5; // 1.25 = 5 quarters

    localparam logic [1:0]  TCA_GPIO_OFF   = 2'h0;
    localparam logic [1:0]  TCA_GPIO_IN    = 2'h1;
    localparam logic [1:0]  TCA_GPIO_OUT_L = 2'h2;
    localparam logic [1:0]  TCA_GPIO_OUT_H = 2'h3;
    localparam logic [1:0]  TCA_TRIG_NLVL  = 2'h0;
    localparam logic [1:0]  TCA_TRIG_PEDGE = 2'h1;
    localparam logic [1:0]  TCA_TRIG_NEDGE = 2'h2;
    localparam logic [1:0]  TCA_TRIG_PLVL  = 2'h3;

endpackage : tca_pkg

/* rtl/tca_regs.sv */
/*
 * Ambient compensation control registers with their sequence-counting
 * timers, low-threshold interrupt gating and general-purpose pin setup.
 * Assumes a serial-port front end that issues one-cycle read and write
 * strobes on clk_in, and a sequencer that pulses once per sequence.
 */
`timescale 1ns/1ps

module tca_regs
    import tca_pkg::*;
#(
    parameter int STAGES = TCA_STAGES                // conversion steps
) (
    input  wire logic              clk_in,           // 25 MHz clock
    input  wire logic              rst_b_in,         // async reset, low
    input  wire logic [9:0]        reg_addr_in,      // register address
    input  wire logic              reg_wr_in,        // write strobe
    input  wire logic              reg_rd_in,        // read strobe
    input  wire logic [15:0]       reg_wdata_in,     // write data
    output logic [15:0]            reg_rdata_out,    // read data
    input  wire logic              seq_done_in,      // sequence complete
    input  wire logic              full_power_in,    // full power mode
    input  wire logic              near_touch_in,    // proximity seen
    input  wire logic [STAGES-1:0] stage_low_in,     // low threshold hit
    input  wire logic              gpio_assert_in,   // pin output request
    input  wire logic              gpio_pin_in,      // pin level
    output logic                   gpio_pin_out,     // pin drive value
    output logic                   gpio_oe_out,      // pin drive enable
    output logic                   gpio_trig_out,    // pin trigger seen
    output logic                   fifo_admit_out,   // admit this result
    output logic                   cal_suspend_out,  // calibration held
    output logic                   power_drop_out,   // go to low power
    output logic                   force_recal_out,  // recalibrate all
    output logic                   seq_restart_out,  // restart sequencer
    output logic [7:0]             near_recal_lvl_out,  // recal level
    output logic [5:0]             near_rate_out,       // detection rate
    output logic [1:0]             slow_update_lvl_out, // slow update
    output logic [9:0]             fp_recal_time_out,   // full power time
    output logic [5:0]             lp_recal_time_out,   // low power time
    output logic                   low_irq_out       // low irq, high
);

    // ------------------------------------------------------------------
    // register storage and decode
    // ------------------------------------------------------------------
    logic [14:0] ctrl_a_ff;
    logic [15:0] ctrl_b_ff;
    logic [15:0] ctrl_c_ff;
    logic [15:0] lowen_ff;
    logic        restart_ff;
    logic [15:0] rdata_ff;
    logic [3:0]  skip_ff;
    logic [9:0]  hold_ff;
    logic [9:0]  idle_ff;
    logic        drop_ff;
    logic [STAGES-1:0] low_src;

    wire sel_a = (reg_addr_in == TCA_OFS_CTRL_A);
    wire sel_b = (reg_addr_in == TCA_OFS_CTRL_B);
    wire sel_c = (reg_addr_in == TCA_OFS_CTRL_C);
    wire sel_e = (reg_addr_in == TCA_OFS_LOWEN);
    wire wr_a  = reg_wr_in & sel_a;

    wire [15:0] rd_mux = sel_a ? {1'b0, ctrl_a_ff} :
                         sel_b ? ctrl_b_ff :
                         sel_c ? ctrl_c_ff :
                         sel_e ? lowen_ff : 16'h0000;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_a_ff <= TCA_RST_CTRL_A[14:0];
            ctrl_b_ff <= TCA_RST_CTRL_B;
            ctrl_c_ff <= TCA_RST_CTRL_C;
            lowen_ff  <= TCA_RST_LOWEN;
        end else if (reg_wr_in) begin
            if (sel_a) ctrl_a_ff <= reg_wdata_in[14:0];
            if (sel_b) ctrl_b_ff <= reg_wdata_in;
            if (sel_c) ctrl_c_ff <= reg_wdata_in;
            if (sel_e) lowen_ff  <= reg_wdata_in;
        end
    end

    // restart bit never stores: it leaves as a one-cycle pulse
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            restart_ff <= 1'b0;
            rdata_ff   <= 16'h0000;
        end else begin
            restart_ff <= wr_a & reg_wdata_in[TCA_RESTART_BIT];
            if (reg_rd_in) rdata_ff <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // field views
    // ------------------------------------------------------------------
    wire [3:0] skip_raw = ctrl_a_ff[TCA_SKIP_LSB +: 4];
    // an out-of-range count is clamped rather than wrapping
    wire [3:0] skip_n   = (skip_raw > TCA_SKIP_MAX) ? TCA_SKIP_MAX
                                                    : skip_raw;
    wire [3:0] fp_hold  = ctrl_a_ff[TCA_FPHOLD_LSB +: 4];
    wire [3:0] lp_hold  = ctrl_a_ff[TCA_LPHOLD_LSB +: 4];
    wire [1:0] tmo_sel  = ctrl_a_ff[TCA_TMO_LSB +: 2];
    wire [9:0] fp_len   = {2'b00, fp_hold, 4'h0};
    wire [9:0] lp_len   = {4'h0, lp_hold, 2'b00};
    wire [3:0] quarters = TCA_TMO_BASE + {2'b00, tmo_sel};
    // quarters of the full power hold: hold x16 x (5..8) / 4
    wire [9:0] tmo_len  = 10'(fp_hold * quarters * 4'h4);

    // ------------------------------------------------------------------
    // sequence-driven timers
    // ------------------------------------------------------------------
    wire [9:0] hold_len = full_power_in ? fp_len : lp_len;
    wire       admit    = seq_done_in & (skip_ff == 4'h0);

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            skip_ff <= 4'h0;
            hold_ff <= 10'h000;
            idle_ff <= 10'h000;
            drop_ff <= 1'b0;
        end else begin
            if (restart_ff)
                skip_ff <= 4'h0;
            else if (seq_done_in)
                skip_ff <= admit ? skip_n : skip_ff - 4'h1;
            if (near_touch_in)
                hold_ff <= hold_len;
            else if (seq_done_in && hold_ff != 10'h000)
                hold_ff <= hold_ff - 10'h001;
            drop_ff <= 1'b0;
            if (near_touch_in || !full_power_in)
                idle_ff <= 10'h000;
            else if (seq_done_in) begin
                if (idle_ff + 10'h001 >= tmo_len) begin
                    idle_ff <= 10'h000;
                    drop_ff <= 1'b1;
                end else
                    idle_ff <= idle_ff + 10'h001;
            end
        end
    end

    // ------------------------------------------------------------------
    // low threshold interrupt gating
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < STAGES; gi++) begin : g_low
            assign low_src[gi] = lowen_ff[gi] & stage_low_in[gi];
        end
    endgenerate

    logic irq_ff;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) irq_ff <= 1'b0;
        else           irq_ff <= |low_src;
    end

    // ------------------------------------------------------------------
    // general-purpose pin
    // ------------------------------------------------------------------
    tca_gpio_pin u_gpio (
        .clk_in     (clk_in),
        .rst_b_in   (rst_b_in),
        .setup_in   (lowen_ff[TCA_GPIO_SETUP_LSB +: 2]),
        .trig_in    (lowen_ff[TCA_GPIO_TRIG_LSB +: 2]),
        .assert_in  (gpio_assert_in),
        .pin_in     (gpio_pin_in),
        .pin_out    (gpio_pin_out),
        .pin_oe_out (gpio_oe_out),
        .trig_out   (gpio_trig_out)
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign reg_rdata_out       = rdata_ff;
    assign fifo_admit_out      = admit;
    assign cal_suspend_out     = (hold_ff != 10'h000);
    assign power_drop_out      = drop_ff;
    assign force_recal_out     = ctrl_a_ff[TCA_FORCE_BIT];
    assign seq_restart_out     = restart_ff;
    assign near_recal_lvl_out  = ctrl_b_ff[TCA_NEAR_LVL_LSB +: 8];
    assign near_rate_out       = ctrl_b_ff[TCA_NEAR_RATE_LSB +: 6];
    assign slow_update_lvl_out = ctrl_b_ff[TCA_SLOW_LVL_LSB +: 2];
    assign fp_recal_time_out   = ctrl_c_ff[TCA_FPRECAL_LSB +: 10];
    assign lp_recal_time_out   = ctrl_c_ff[TCA_LPRECAL_LSB +: 6];
    assign low_irq_out         = irq_ff;

endmodule // tca_regs
